// >>> frp_gate.sv
// Purpose: Decides whether each flash read, write or erase may proceed
// Assumes: Option bytes are stable on opt_i when reset is released
// Notes:   Grant and error are combinational; level changes only by downgrade
//
// What this block does
// [RULE1] Level field encodes 0, 0.5, 1 and 2; level 0 restricts nobody.
// [RULE2] Level 0.5 is accepted only with the security extension enabled.
// [RULE3] Level 0.5 allows all non-secure reads and writes unless write protected.
// [RULE4] Level 0.5 rejects debug accesses to secure flash, non-secure remain allowed.
// [RULE5] Level 1 blocks flash with debugger connected or SRAM/loader boot selected.
// [RULE6] Level 1 with security extension keeps non-secure debug, refuses SRAM boot.
// [RULE7] Downgrade from level 1 needs the correct password when guarded.
// [RULE8] Level 2 disables debug, RAM boot and loader boot.
// [RULE9] Without secret key level 2 is permanent and debug stays disabled.
// [RULE10] With secret key, debug authentication allows downgrade from 2 to 1.
// [RULE11] Two page aligned write protected areas refuse program and erase.
// [RULE12] Downgrade from 1 to 0 erases the whole main array.
// [RULE13] Downgrade from 1 to 0.5 or 0 clears backup registers.
// [RULE14] Downgrade from 1 to 0.5 or 0 clears every SRAM.
// [RULE15] Each OTP row takes one programming operation, later writes refused; the code clears the used marks at reset.
// [RULE16] Requests judged combinationally; refused ones answer with an error.
// [RULE17] Level and protected areas load at reset; areas held until next reset, level until downgrade.
`timescale 1ns/100ps
module frp_gate
	import frp_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_i,
	// Option bytes and straps
	input wire frp_opt_s opt_i,
	input wire logic security_extension_enable_i,
	input wire frp_boot_e boot_sel_i,
	input wire logic dbg_connected_i,
	// Access request and answer
	input wire frp_req_s req_i,
	output frp_rsp_s rsp_o,
	// Downgrade request
	input wire frp_dg_s dg_i,
	input wire logic erase_done_i,
	output logic dg_done_o,
	output logic dg_fail_o,
	output logic busy_o,
	// Erase and clear strobes
	output logic mass_erase_o,
	output logic bkp_clear_o,
	output logic sram_clear_o,
	// Status
	output frp_lvl_t readout_protection_level_o,
	output logic dbg_ns_en_o,
	output logic dbg_s_en_o,
	output logic dbg_auth_en_o,
	output logic boot_ok_o
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {DG_IDLE, DG_ERASE, DG_CLEAR, DG_DONE} frp_dg_e;

	frp_dg_e dg_state_r;
	frp_lvl_t level_r;
	frp_lvl_t dg_tgt_r;
	logic load_r;
	logic security_extension_enable_r;
	logic pwd_guard_r;
	frp_pwd_t pwd_r;
	logic key_set_r;
	frp_pwd_t key_r;
	frp_wpa_s wpa0_r;
	frp_wpa_s wpa1_r;
	logic [OTP_ROWS-1:0] otp_used_r;
	logic wrp_hit;
	logic busy;
	logic grant;
	logic [OTP_ROW_W-1:0] otp_row;

	// True when the page falls inside an enabled protected area
	function automatic logic in_area(frp_page_t pg, frp_wpa_s a);
		in_area = a.en && (pg >= a.first) && (pg <= a.last);
	endfunction

	// ----------------------------------------------------------------
	// Option load after reset release
	// ----------------------------------------------------------------
	// Load pending flag, set by reset and cleared on the first edge
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			load_r <= 1'b1;
		end else begin
			load_r <= 1'b0;
		end
	end

	// Option copies held constant until next reset
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			security_extension_enable_r <= 1'b0;
			pwd_guard_r <= 1'b1;
			pwd_r <= '0;
			key_set_r <= 1'b0;
			key_r <= '0;
			wpa0_r <= '0;
			wpa1_r <= '0;
		end else if (load_r) begin
			security_extension_enable_r <= security_extension_enable_i; // see [RULE17]
			pwd_guard_r <= opt_i.pwd_guard;
			pwd_r <= opt_i.pwd;
			key_set_r <= opt_i.key_set;
			key_r <= opt_i.key;
			wpa0_r <= opt_i.wpa0; // see [RULE11]
			wpa1_r <= opt_i.wpa1;
		end
	end

	// Level register: loaded once, then changed only by a finished downgrade
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			level_r <= LVL_RST;
		end else if (load_r) begin
			if (opt_i.level == LVL_05 && !security_extension_enable_i) begin
				level_r <= LVL_1; // see [RULE2]
			end else begin
				level_r <= opt_i.level; // see [RULE1] [RULE17]
			end
		end else if (dg_state_r == DG_DONE) begin
			level_r <= dg_tgt_r;
		end
	end

	// ----------------------------------------------------------------
	// Downgrade sequencer
	// ----------------------------------------------------------------
	// Checks the request, then erases, clears and commits in that order
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			dg_state_r <= DG_IDLE;
			dg_tgt_r <= LVL_RST;
		end else begin
			unique case (dg_state_r)
				DG_IDLE: begin
					if (dg_i.valid && !load_r) begin
						dg_tgt_r <= dg_i.target;
						if (level_r == LVL_1 && (!pwd_guard_r || dg_i.pwd == pwd_r)) begin // see [RULE7]
							if (dg_i.target == LVL_0) begin
								dg_state_r <= DG_ERASE; // see [RULE12]
							end else if (dg_i.target == LVL_05 && security_extension_enable_r) begin
								dg_state_r <= DG_CLEAR; // see [RULE2]
							end
						end else if (level_r == LVL_2 && key_set_r && dg_i.auth_port
							&& dg_i.target == LVL_1 && dg_i.pwd == key_r) begin
							dg_state_r <= DG_DONE; // see [RULE9] [RULE10]
						end
					end
				end
				DG_ERASE: begin
					if (erase_done_i) begin
						dg_state_r <= DG_CLEAR;
					end
				end
				DG_CLEAR: begin
					dg_state_r <= DG_DONE;
				end
				DG_DONE: begin
					dg_state_r <= DG_IDLE;
				end
			endcase
		end
	end

	// Failure strobe for a refused downgrade request
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			dg_fail_o <= 1'b0;
		end else begin
			dg_fail_o <= 1'b0;
			if (dg_state_r == DG_IDLE && dg_i.valid && !load_r) begin
				dg_fail_o <= 1'b1;
				if (level_r == LVL_1 && (!pwd_guard_r || dg_i.pwd == pwd_r)
					&& (dg_i.target == LVL_0 || (dg_i.target == LVL_05 && security_extension_enable_r))) begin
					dg_fail_o <= 1'b0;
				end
				if (level_r == LVL_2 && key_set_r && dg_i.auth_port
					&& dg_i.target == LVL_1 && dg_i.pwd == key_r) begin
					dg_fail_o <= 1'b0;
				end
			end
		end
	end

	// Sequencer strobes
	assign mass_erase_o = (dg_state_r == DG_ERASE); // see [RULE12]
	assign bkp_clear_o = (dg_state_r == DG_CLEAR) && (dg_tgt_r != LVL_1); // see [RULE13]
	assign sram_clear_o = (dg_state_r == DG_CLEAR) && (dg_tgt_r != LVL_1); // see [RULE14]
	assign dg_done_o = (dg_state_r == DG_DONE);
	assign busy = load_r || (dg_state_r != DG_IDLE);
	assign busy_o = busy;

	// ----------------------------------------------------------------
	// Access decision
	// ----------------------------------------------------------------
	assign wrp_hit = in_area(req_i.addr[PAGE_LSB +: PAGE_W], wpa0_r)
		|| in_area(req_i.addr[PAGE_LSB +: PAGE_W], wpa1_r);
	assign otp_row = req_i.addr[OTP_ROW_LSB +: OTP_ROW_W];

	// Judges the current request against level, source, boot and areas
	always_comb begin
		logic ext;
		ext = 1'b0;
		grant = 1'b1;
		ext = (req_i.src != SRC_USER);
		unique case (level_r)
			LVL_0: begin
				grant = 1'b1; // see [RULE1]
			end
			LVL_05: begin
				if (req_i.src == SRC_DEBUG && req_i.secure) begin
					grant = 1'b0; // see [RULE4]
				end
			end
			LVL_1: begin
				if (req_i.area == AREA_MAIN && (ext || dbg_connected_i || boot_sel_i != BOOT_FLASH)) begin
					grant = 1'b0; // see [RULE5]
				end
				if (req_i.src == SRC_RAMBOOT && security_extension_enable_r) begin
					grant = 1'b0; // see [RULE6]
				end
			end
			LVL_2: begin
				if (ext) begin
					grant = 1'b0; // see [RULE8]
				end
				if (req_i.area == AREA_OPT && req_i.op != OP_READ) begin
					grant = 1'b0;
				end
			end
		endcase
		if (req_i.area == AREA_MAIN && req_i.op != OP_READ && wrp_hit) begin
			grant = 1'b0; // see [RULE3] [RULE11]
		end
		if (req_i.area == AREA_SYS && req_i.op != OP_READ) begin
			grant = 1'b0;
		end
		if ((req_i.area == AREA_OPT || req_i.area == AREA_OTP) && req_i.op == OP_ERASE) begin
			grant = 1'b0;
		end
		if (req_i.area == AREA_OTP && req_i.op == OP_WRITE && otp_used_r[otp_row]) begin
			grant = 1'b0; // see [RULE15]
		end
		if (busy) begin
			grant = 1'b0;
		end
	end

	// Answer: grant on success, error on a refused valid request
	assign rsp_o.grant = req_i.valid && grant; // see [RULE16]
	assign rsp_o.err = req_i.valid && !grant; // see [RULE16]

	// OTP rows marked used by their first granted write
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			otp_used_r <= '0;
		end else if (rsp_o.grant && req_i.area == AREA_OTP && req_i.op == OP_WRITE) begin
			otp_used_r[otp_row] <= 1'b1; // see [RULE15]
		end
	end

	// ----------------------------------------------------------------
	// Debug and boot permissions
	// ----------------------------------------------------------------
	// Registered from level, security extension and boot selection
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			dbg_ns_en_o <= 1'b0;
			dbg_s_en_o <= 1'b0;
			dbg_auth_en_o <= 1'b0;
			boot_ok_o <= 1'b0;
		end else begin
			dbg_ns_en_o <= (level_r != LVL_2); // see [RULE6] [RULE8]
			dbg_s_en_o <= (level_r == LVL_0);
			dbg_auth_en_o <= (level_r == LVL_2) && key_set_r; // see [RULE9]
			unique case (level_r)
				LVL_0, LVL_05: boot_ok_o <= 1'b1;
				LVL_1: boot_ok_o <= !(security_extension_enable_r && boot_sel_i == BOOT_SRAM); // see [RULE6]
				LVL_2: boot_ok_o <= (boot_sel_i == BOOT_FLASH); // see [RULE8]
			endcase
		end
	end

	assign readout_protection_level_o = level_r;

endmodule // frp_gate

// >>> frp_pkg.sv
// Purpose: Shared types and constants for the flash readout protection gate
// Assumes: 1 MB main array of 8 KB pages, 512 byte OTP in 16 byte rows
// Notes:   Level codes are fixed so option bytes map directly onto them
package frp_pkg;

	// ----------------------------------------------------------------
	// Protection levels
	// ----------------------------------------------------------------
	typedef logic [1:0] frp_lvl_t;
	localparam frp_lvl_t LVL_0 = 2'h0;
	localparam frp_lvl_t LVL_05 = 2'h1;
	localparam frp_lvl_t LVL_1 = 2'h2;
	localparam frp_lvl_t LVL_2 = 2'h3;
	localparam frp_lvl_t LVL_RST = LVL_2;

	// ----------------------------------------------------------------
	// Address layout
	// ----------------------------------------------------------------
	localparam int ADDR_W = 20;
	localparam int PAGE_LSB = 13;
	localparam int PAGE_W = 7;
	localparam int OTP_ROW_LSB = 4;
	localparam int OTP_ROW_W = 5;
	localparam int OTP_ROWS = 32;
	localparam int PWD_W = 32;

	typedef logic [PAGE_W-1:0] frp_page_t;
	typedef logic [PWD_W-1:0] frp_pwd_t;

	// ----------------------------------------------------------------
	// Request kinds
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {OP_READ, OP_WRITE, OP_ERASE} frp_op_e;
	typedef enum logic [1:0] {AREA_MAIN, AREA_SYS, AREA_OPT, AREA_OTP} frp_area_e;
	typedef enum logic [1:0] {SRC_USER, SRC_DEBUG, SRC_RAMBOOT, SRC_LOADER} frp_src_e;
	typedef enum logic [1:0] {BOOT_FLASH, BOOT_SRAM, BOOT_LOADER} frp_boot_e;

	// ----------------------------------------------------------------
	// Carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic valid;
		frp_op_e op;
		frp_area_e area;
		frp_src_e src;
		logic secure;
		logic [ADDR_W-1:0] addr;
	} frp_req_s;

	typedef struct packed {
		logic grant;
		logic err;
	} frp_rsp_s;

	typedef struct packed {
		logic en;
		frp_page_t first;
		frp_page_t last;
	} frp_wpa_s;

	typedef struct packed {
		frp_lvl_t level;
		logic pwd_guard;
		frp_pwd_t pwd;
		logic key_set;
		frp_pwd_t key;
		frp_wpa_s wpa0;
		frp_wpa_s wpa1;
	} frp_opt_s;

	typedef struct packed {
		logic valid;
		frp_lvl_t target;
		logic auth_port;
		frp_pwd_t pwd;
	} frp_dg_s;

endpackage

// >>> frp_gate_sva.sv
// Purpose: Port assertions for the flash protection gate
// Assumes: Option bytes stay steady while the gate runs
// Notes:   Bound to every gate instance
`timescale 1ns/100ps
module frp_gate_sva
	import frp_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_i,
	// Inputs watched
	input wire frp_opt_s opt_i,
	input wire frp_boot_e boot_sel_i,
	input wire logic dbg_connected_i,
	input wire frp_req_s req_i,
	input wire frp_dg_s dg_i,
	input wire logic erase_done_i,
	// Outputs watched
	input wire frp_rsp_s rsp_o,
	input wire logic dg_done_o,
	input wire logic dg_fail_o,
	input wire logic busy_o,
	input wire logic mass_erase_o,
	input wire logic bkp_clear_o,
	input wire logic sram_clear_o,
	input wire frp_lvl_t readout_protection_level_o,
	input wire logic dbg_ns_en_o,
	input wire logic dbg_s_en_o,
	input wire logic boot_ok_o
);
	// ------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);
	wire frp_lvl_t lvl = readout_protection_level_o;
	wire frp_page_t pg = req_i.addr[PAGE_LSB +: PAGE_W];
	a_busy_refuses: assert property (req_i.valid && busy_o |-> rsp_o.err && !rsp_o.grant)
		else $error("access granted while busy");
	a_l2_nonuser_err: assert property (req_i.valid && lvl == LVL_2 && req_i.src != SRC_USER |-> rsp_o.err)
		else $error("non-user access allowed at level 2");
	a_l1_dbg_blocks: assert property (req_i.valid && lvl == LVL_1 && dbg_connected_i && req_i.area == AREA_MAIN
		|-> rsp_o.err)
		else $error("main flash open with debugger at level 1");
	a_l2_perm_off: assert property ((lvl == LVL_2 && boot_sel_i != BOOT_FLASH)[*2]
		|-> !dbg_ns_en_o && !dbg_s_en_o && !boot_ok_o)
		else $error("debug or boot allowed at level 2");
	a_wpa_refuses: assert property (req_i.valid && req_i.op != OP_READ && req_i.area == AREA_MAIN && opt_i.wpa0.en
		&& pg >= opt_i.wpa0.first && pg <= opt_i.wpa0.last |-> rsp_o.err)
		else $error("protected page modified");
	a_l2_locked: assert property (lvl == LVL_2 && !opt_i.key_set && dg_i.valid && !busy_o |=> dg_fail_o)
		else $error("keyless level 2 downgrade not refused");
	a_erase_holds: assert property (mass_erase_o && !erase_done_i |=> mass_erase_o)
		else $error("mass erase dropped early");
	a_clear_then_done: assert property (bkp_clear_o |-> sram_clear_o ##1 dg_done_o)
		else $error("clear strobes out of order");
endmodule // frp_gate_sva

bind frp_gate frp_gate_sva u_sva(.clk_sys_i, .rst_i, .opt_i, .boot_sel_i, .dbg_connected_i, .req_i, .dg_i,
	.erase_done_i, .rsp_o, .dg_done_o, .dg_fail_o, .busy_o, .mass_erase_o, .bkp_clear_o, .sram_clear_o,
	.readout_protection_level_o, .dbg_ns_en_o, .dbg_s_en_o, .boot_ok_o);

// >>> frp_host.sv
// Purpose: Bus master and debug port model facing the gate
// Assumes: The answer settles within the request cycle
// Notes:   Released lines carry the inverse of the last value
`timescale 1ns/100ps
module frp_host
	import frp_pkg::*;
(
	// Clock
	input wire logic clk_sys_i,
	// Gate side
	output frp_req_s req_o,
	input wire frp_rsp_s rsp_i,
	output frp_dg_s dg_o,
	input wire logic dg_fail_i
);
	// ------------------------------------------------------------
	// Transfers
	// ------------------------------------------------------------
	initial begin
		req_o = '0;
		dg_o = '0;
	end
	// One access held a cycle, answer taken at the edge that ends it
	task automatic access(input frp_req_s r, output frp_rsp_s s);
		frp_req_s t;
		t = ~r;
		t.valid = 1'b0;
		@(posedge clk_sys_i) req_o <= r;
		@(posedge clk_sys_i);
		s = rsp_i;
		req_o <= t;
	endtask
	// Downgrade pulse carrying the password or key answer
	task automatic downgrade(input frp_dg_s d, output logic f);
		frp_dg_s t;
		t = ~d;
		t.valid = 1'b0;
		@(posedge clk_sys_i) dg_o <= d;
		@(posedge clk_sys_i) dg_o <= t;
		@(negedge clk_sys_i) f = dg_fail_i;
	endtask
endmodule // frp_host

// >>> flash_readout_protection_gate_bench.sv
// Purpose: Self-checking bench for the flash protection gate
// Assumes: Option bytes change only while reset is held
// Notes:   Table rows run at level 1; later cases reload options
`timescale 1ns/100ps
module flash_readout_protection_gate_bench
	import frp_pkg::*;
;
	// ------------------------------------------------------------
	// Stimulus and checking
	// ------------------------------------------------------------
	typedef struct {frp_req_s r; logic g;} frp_row_s;
	logic clk_sys_i, rst_i, ext, dbgc, edone, dgd, dgf, busy, me, bc, sc, f;
	logic dns, dse, dae, bok;
	frp_boot_e boot;
	frp_opt_s opt, o;
	frp_req_s req;
	frp_rsp_s rsp, s;
	frp_dg_s dg;
	frp_lvl_t lvl;
	frp_row_s rows[8];
	int error_cnt = 0, cmp_count = 0, nclr = 0, ndone = 0;
	frp_gate DUT(.clk_sys_i, .rst_i, .opt_i(opt), .security_extension_enable_i(ext), .boot_sel_i(boot),
		.dbg_connected_i(dbgc), .req_i(req), .rsp_o(rsp), .dg_i(dg), .erase_done_i(edone), .dg_done_o(dgd),
		.dg_fail_o(dgf), .busy_o(busy), .mass_erase_o(me), .bkp_clear_o(bc), .sram_clear_o(sc),
		.readout_protection_level_o(lvl), .dbg_ns_en_o(dns), .dbg_s_en_o(dse), .dbg_auth_en_o(dae),
		.boot_ok_o(bok));
	frp_host u_host(.clk_sys_i, .req_o(req), .rsp_i(rsp), .dg_o(dg), .dg_fail_i(dgf));
	// Clock
	initial begin
		clk_sys_i = 1'b0;
		forever #50 clk_sys_i = ~clk_sys_i;
	end
	// Counts clear strobes and completions
	always @(negedge clk_sys_i) begin
		if (bc === 1'b1 && sc === 1'b1) nclr++;
		if (dgd === 1'b1) ndone++;
	end
	task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	function automatic frp_req_s q(frp_op_e p, frp_area_e a, frp_src_e c, logic sec, logic [19:0] ad);
		q = '{1'b1, p, a, c, sec, ad};
	endfunction
	task automatic acc(frp_req_s r, logic g);
		u_host.access(r, s);
		chk("grant", {s.grant, s.err}, {g, ~g});
	endtask
	task automatic reload(logic e);
		@(posedge clk_sys_i);
		rst_i <= 1'b1;
		opt <= o;
		ext <= e;
		repeat (8) @(posedge clk_sys_i);
		chk("reset level", {lvl, busy}, {LVL_RST, 1'b1});
		rst_i <= 1'b0;
		repeat (3) @(posedge clk_sys_i);
	endtask
	task automatic down(frp_lvl_t l, logic ap, frp_pwd_t p, logic ef);
		nclr = 0;
		ndone = 0;
		u_host.downgrade('{1'b1, l, ap, p}, f);
		chk("dg fail", f, ef);
	endtask
	task automatic walk(logic er, frp_lvl_t l);
		chk("mass erase", me, er);
		if (er) begin
			@(posedge clk_sys_i) edone <= 1'b1;
			@(posedge clk_sys_i) edone <= 1'b0;
		end
		repeat (6) @(posedge clk_sys_i);
		chk("clears", nclr, 32'(l != LVL_1));
		chk("done", ndone, 32'h1);
		chk("new level", lvl, l);
	endtask
	task automatic tally_and_finish;
		$display("compares %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	// Watchdog
	initial begin
		repeat (3000) @(posedge clk_sys_i);
		error_cnt++;
		tally_and_finish;
	end
	// Main sequence
	initial begin
		rst_i = 1'b1; ext = 1'b0; dbgc = 1'b0; edone = 1'b0; boot = BOOT_FLASH; opt = '0;
		o = '0; o.level = LVL_1; o.pwd_guard = 1'b1; o.pwd = 32'hC0DE0001; o.wpa0 = '{1'b1, 7'h04, 7'h05};
		rows = '{'{q(OP_READ, AREA_MAIN, SRC_USER, 0, 20'h00000), 1}, '{q(OP_READ, AREA_MAIN, SRC_DEBUG, 0, 20'h0), 0},
			'{q(OP_WRITE, AREA_MAIN, SRC_USER, 0, 20'h08000), 0}, '{q(OP_ERASE, AREA_MAIN, SRC_USER, 0, 20'h0A000), 0},
			'{q(OP_ERASE, AREA_MAIN, SRC_USER, 0, 20'h0C000), 1}, '{q(OP_WRITE, AREA_SYS, SRC_USER, 0, 20'h0), 0},
			'{q(OP_ERASE, AREA_OTP, SRC_USER, 0, 20'h00000), 0}, '{q(OP_READ, AREA_OPT, SRC_DEBUG, 0, 20'h0), 1}};
		reload(1'b0);
		chk("l1 debug boot", {dns, dse, dae, bok}, 4'h9);
		foreach (rows[i]) acc(rows[i].r, rows[i].g);
		acc(q(OP_WRITE, AREA_OTP, SRC_USER, 0, 20'h00010), 1);
		acc(q(OP_WRITE, AREA_OTP, SRC_USER, 0, 20'h00010), 0);
		@(posedge clk_sys_i) dbgc <= 1'b1;
		acc(rows[0].r, 0);
		@(posedge clk_sys_i) {dbgc, boot} <= {1'b0, BOOT_SRAM};
		acc(rows[0].r, 0);
		@(posedge clk_sys_i) boot <= BOOT_FLASH;
		down(LVL_0, 0, 32'hC0DE0002, 1);
		down(LVL_0, 0, 32'hC0DE0001, 0);
		walk(1, LVL_0);
		acc(q(OP_READ, AREA_MAIN, SRC_DEBUG, 1, 20'h0), 1);
		$display("level 1 test done");
		o.level = LVL_05;
		reload(1'b0);
		chk("level", lvl, LVL_1);
		o.level = LVL_1; o.pwd_guard = 1'b0;
		reload(1'b1);
		acc(q(OP_READ, AREA_OPT, SRC_RAMBOOT, 0, 20'h0), 0);
		down(LVL_05, 0, 32'h0, 0);
		walk(0, LVL_05);
		acc(q(OP_READ, AREA_MAIN, SRC_DEBUG, 1, 20'h20000), 0);
		acc(q(OP_READ, AREA_MAIN, SRC_DEBUG, 0, 20'h20000), 1);
		acc(q(OP_WRITE, AREA_MAIN, SRC_USER, 0, 20'h20000), 1);
		$display("level 0.5 test done");
		o.level = LVL_2; o.key = 32'h5EC0_0042;
		@(posedge clk_sys_i) boot <= BOOT_LOADER;
		reload(1'b0);
		chk("l2 debug boot", {dns, dse, dae, bok}, 4'h0);
		acc(q(OP_READ, AREA_OPT, SRC_DEBUG, 0, 20'h0), 0);
		down(LVL_1, 1, 32'h5EC0_0042, 1);
		o.key_set = 1'b1;
		reload(1'b0);
		chk("l2 auth port", {dns, dae}, 2'h1);
		down(LVL_1, 1, 32'h5EC0_0042, 0);
		walk(0, LVL_1);
		$display("level 2 test done");
		tally_and_finish;
	end
endmodule // flash_readout_protection_gate_bench
